//--- design/tltg_core.v
// Thrust limit selection and software travel guard for a linear servo.
// Assumes control-loop inputs are synchronous to sys_clk; software port as
// address, write/read strobes, read data one cycle after the read strobe.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tltg_consts.vh"
// How it works
// - Limit picked by direction or switch command
// - Switching only position/velocity mode, servo on
// - Thrust mode uses primary limit only
// - Primary limit 0..500 percent caps thrust
// - Secondary limit 0..500 caps when selected
// - Switch command applies positive direction limit
// - Switch command applies negative direction limit
// - Max limit = 100*peak/(rated*sqrt2)
// - Beyond range raises software limit alarm
// - Guard only in position mode, servo on
// - Trip requests configured alarm stop sequence
// - Guard suppressed during frequency response test
// - Margin 0..1000 pole pitches per side
// - No command yet: margin around position
// - Positive commands extend range upward
// - Negative commands widen range downward
// - Input range collapsed onto motor position on clear conditions
module tltg_core (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  input wire [1:0] control_mode,
  input wire servo_on,
  input wire thrust_limit_switch_cmd,
  input wire move_dir_neg,
  input wire freq_resp_active,
  input wire deviation_clear,
  input wire position_init,
  input wire cmd_valid,
  input wire signed [31:0] cmd_delta,
  input wire signed [31:0] motor_position,
  output reg [9:0] pos_thrust_limit_q,
  output reg [9:0] neg_thrust_limit_q,
  output reg software_limit_alarm_q,
  output reg [2:0] alarm_stop_req_q
);
  reg [9:0] primary_thrust_limit_q;
  reg [9:0] secondary_thrust_limit_q;
  reg [9:0] positive_dir_limit_q;
  reg [9:0] negative_dir_limit_q;
  reg [2:0] limit_method_select_q;
  reg [9:0] travel_margin_q;
  reg [15:0] pole_pitch_q;
  reg [15:0] peak_motor_current_q;
  reg [15:0] rated_rms_current_q;
  reg [2:0] alarm_stop_sequence_q;
  reg [9:0] max_limit_q;
  reg div_start_q;
  reg have_cmd_q;
  reg armed_q;
  reg signed [31:0] anchor_q;
  reg signed [31:0] cmd_pos_q;
  reg signed [31:0] range_lo_q;
  reg signed [31:0] range_hi_q;
  reg [9:0] pos_d;
  reg [9:0] neg_d;
  wire [31:0] quotient;
  wire div_done;
  wire range_clear;
  wire guard_on;
  wire switch_ok;
  wire signed [31:0] margin_len;
  wire signed [31:0] cmd_next;
  wire signed [31:0] bound_lo;
  wire signed [31:0] bound_hi;
  wire [31:0] div_num;
  wire [31:0] div_den;

  // Clamp a written setting to its legal ceiling
  function [9:0] clamp10;
    input [31:0] value;
    input [9:0] ceiling;
    begin
      clamp10 = (value > {22'h0, ceiling}) ? ceiling : value[9:0];
    end
  endfunction

  // A percentage limit never exceeds what the motor can deliver
  function [9:0] cap_limit;
    input [9:0] setting;
    input [9:0] ceiling;
    begin
      cap_limit = (setting > ceiling) ? ceiling : setting;
    end
  endfunction

  // 100*peak/(rated*sqrt2); sqrt2 held in Q14 so dividend is scaled by 2^14
  // Peak settings above 2621 wrap the 32-bit product; real motors sit far below
  assign div_num = {2'h0, peak_motor_current_q, 14'h0} * 32'h00000064;
  assign div_den = {16'h0, rated_rms_current_q} * {16'h0, `TLTG_SQRT2_Q14};

  tltg_divider u_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(div_start_q),
    .dividend(div_num),
    .divisor(div_den),
    .quotient_q(quotient),
    .done_q(div_done)
  );

  // Register writes and the limit-ceiling recompute trigger
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      primary_thrust_limit_q <= `TLTG_RST_LIMIT;
      secondary_thrust_limit_q <= `TLTG_RST_LIMIT;
      positive_dir_limit_q <= `TLTG_RST_LIMIT;
      negative_dir_limit_q <= `TLTG_RST_LIMIT;
      limit_method_select_q <= `TLTG_RST_METHOD;
      travel_margin_q <= `TLTG_RST_MARGIN;
      pole_pitch_q <= `TLTG_RST_PITCH;
      peak_motor_current_q <= `TLTG_RST_PEAK;
      rated_rms_current_q <= `TLTG_RST_RATED;
      alarm_stop_sequence_q <= 3'h0;
      div_start_q <= 1'b1;
    end
    else
    begin
      div_start_q <= 1'b0;
      if (reg_wr)
      begin
        case (reg_addr)
          `TLTG_ADDR_PRIMARY:
            primary_thrust_limit_q <= clamp10(reg_wdata, `TLTG_LIMIT_MAX);
          `TLTG_ADDR_SECONDARY:
            secondary_thrust_limit_q <= clamp10(reg_wdata, `TLTG_LIMIT_MAX);
          `TLTG_ADDR_POS_DIR:
            positive_dir_limit_q <= clamp10(reg_wdata, `TLTG_LIMIT_MAX);
          `TLTG_ADDR_NEG_DIR:
            negative_dir_limit_q <= clamp10(reg_wdata, `TLTG_LIMIT_MAX);
          `TLTG_ADDR_METHOD:
            // Out-of-range methods are ignored, keeping the last legal one
            if (reg_wdata[31:0] >= 32'h1 && reg_wdata[31:0] <= 32'h4)
              limit_method_select_q <= reg_wdata[2:0];
          `TLTG_ADDR_MARGIN:
            travel_margin_q <= clamp10(reg_wdata, `TLTG_MARGIN_MAX);
          `TLTG_ADDR_PITCH:
            pole_pitch_q <= reg_wdata[15:0];
          `TLTG_ADDR_PEAK_CUR:
          begin
            peak_motor_current_q <= reg_wdata[15:0];
            div_start_q <= 1'b1;
          end
          `TLTG_ADDR_RATED_CUR:
          begin
            rated_rms_current_q <= reg_wdata[15:0];
            div_start_q <= 1'b1;
          end
          `TLTG_ADDR_STOP_SEQ:
            alarm_stop_sequence_q <= reg_wdata[2:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      max_limit_q <= `TLTG_LIMIT_MAX;
    else if (div_done)
      max_limit_q <= (quotient > {22'h0, `TLTG_LIMIT_MAX}) ? `TLTG_LIMIT_MAX :
                     quotient[9:0];
  end

  // Limit selection
  assign switch_ok = servo_on && (control_mode == `TLTG_MODE_POS ||
                     control_mode == `TLTG_MODE_VEL);

  always @*
  begin
    pos_d = primary_thrust_limit_q;
    neg_d = primary_thrust_limit_q;
    if (control_mode == `TLTG_MODE_THR)
    begin
      pos_d = primary_thrust_limit_q;
      neg_d = primary_thrust_limit_q;
    end
    else if (switch_ok)
    begin
      case (limit_method_select_q)
        3'h1:
        begin
          // Direction picks primary forward, secondary reverse
          pos_d = primary_thrust_limit_q;
          neg_d = secondary_thrust_limit_q;
        end
        3'h2:
        begin
          pos_d = move_dir_neg ? secondary_thrust_limit_q : primary_thrust_limit_q;
          neg_d = pos_d;
        end
        3'h3:
        begin
          pos_d = thrust_limit_switch_cmd ? secondary_thrust_limit_q : primary_thrust_limit_q;
          neg_d = pos_d;
        end
        3'h4:
        begin
          if (thrust_limit_switch_cmd)
          begin
            pos_d = positive_dir_limit_q;
            neg_d = negative_dir_limit_q;
          end
        end
        default:
        begin
          pos_d = primary_thrust_limit_q;
          neg_d = primary_thrust_limit_q;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pos_thrust_limit_q <= 10'h000;
      neg_thrust_limit_q <= 10'h000;
    end
    else
    begin
      pos_thrust_limit_q <= cap_limit(pos_d, max_limit_q);
      neg_thrust_limit_q <= cap_limit(neg_d, max_limit_q);
    end
  end

  // Travel guard
  assign range_clear = deviation_clear || position_init || !servo_on || !armed_q ||
                       control_mode != `TLTG_MODE_POS;
  assign guard_on = armed_q && servo_on && control_mode == `TLTG_MODE_POS &&
                    !freq_resp_active;
  assign margin_len = $signed({22'h0, travel_margin_q}) *
                      $signed({16'h0, pole_pitch_q});
  assign cmd_next = cmd_pos_q + cmd_delta;
  // The controller must not lean on this guard while hopping modes
  assign bound_lo = (have_cmd_q ? range_lo_q : anchor_q) - margin_len;
  assign bound_hi = (have_cmd_q ? range_hi_q : anchor_q) + margin_len;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      have_cmd_q <= 1'b0;
      anchor_q <= 32'h0;
      cmd_pos_q <= 32'h0;
      range_lo_q <= 32'h0;
      range_hi_q <= 32'h0;
    end
    else if (range_clear)
    begin
      // Position follows the motor while any clear condition holds
      have_cmd_q <= 1'b0;
      anchor_q <= motor_position;
      cmd_pos_q <= motor_position;
      range_lo_q <= motor_position;
      range_hi_q <= motor_position;
    end
    else if (cmd_valid)
    begin
      have_cmd_q <= 1'b1;
      cmd_pos_q <= cmd_next;
      if (cmd_next > range_hi_q)
        range_hi_q <= cmd_next;
      if (cmd_next < range_lo_q)
        range_lo_q <= cmd_next;
    end
  end

  // First edge after reset anchors the range at the motor; the guard waits for it
  // so that a zero anchor left by reset cannot trip the alarm
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      armed_q <= 1'b0;
    else
      armed_q <= 1'b1;
  end

  // Alarm latches until reset; only rst_b clears a software limit trip
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      software_limit_alarm_q <= 1'b0;
      alarm_stop_req_q <= 3'h0;
    end
    else if (!software_limit_alarm_q && guard_on &&
             (motor_position < bound_lo || motor_position > bound_hi))
    begin
      software_limit_alarm_q <= 1'b1;
      alarm_stop_req_q <= alarm_stop_sequence_q;
    end
  end

  // Register reads
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_q <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `TLTG_ADDR_PRIMARY: reg_rdata_q <= {22'h0, primary_thrust_limit_q};
        `TLTG_ADDR_SECONDARY: reg_rdata_q <= {22'h0, secondary_thrust_limit_q};
        `TLTG_ADDR_POS_DIR: reg_rdata_q <= {22'h0, positive_dir_limit_q};
        `TLTG_ADDR_NEG_DIR: reg_rdata_q <= {22'h0, negative_dir_limit_q};
        `TLTG_ADDR_METHOD: reg_rdata_q <= {29'h0, limit_method_select_q};
        `TLTG_ADDR_MARGIN: reg_rdata_q <= {22'h0, travel_margin_q};
        `TLTG_ADDR_PITCH: reg_rdata_q <= {16'h0, pole_pitch_q};
        `TLTG_ADDR_PEAK_CUR: reg_rdata_q <= {16'h0, peak_motor_current_q};
        `TLTG_ADDR_RATED_CUR: reg_rdata_q <= {16'h0, rated_rms_current_q};
        `TLTG_ADDR_STOP_SEQ: reg_rdata_q <= {29'h0, alarm_stop_sequence_q};
        `TLTG_ADDR_CONTROL: reg_rdata_q <= {30'h0, have_cmd_q, guard_on};
        `TLTG_ADDR_STATUS: reg_rdata_q <= {28'h0, alarm_stop_req_q, software_limit_alarm_q};
        `TLTG_ADDR_ACTIVE: reg_rdata_q <= {6'h0, neg_thrust_limit_q, 6'h0, pos_thrust_limit_q};
        `TLTG_ADDR_MAX_LIMIT: reg_rdata_q <= {22'h0, max_limit_q};
        `TLTG_ADDR_RANGE_LO: reg_rdata_q <= bound_lo;
        `TLTG_ADDR_RANGE_HI: reg_rdata_q <= bound_hi;
        default: reg_rdata_q <= 32'h0;
      endcase
    end
    else
      reg_rdata_q <= 32'h0;
  end
endmodule
`default_nettype wire

//--- design/tltg_consts.vh
// Constants for the thrust limit selector and travel guard.
// Assumes inclusion by bare name from design files only.
`ifndef TLTG_CONSTS_VH
`define TLTG_CONSTS_VH
`define TLTG_ADDR_PRIMARY 4'h0
`define TLTG_ADDR_SECONDARY 4'h1
`define TLTG_ADDR_POS_DIR 4'h2
`define TLTG_ADDR_NEG_DIR 4'h3
`define TLTG_ADDR_METHOD 4'h4
`define TLTG_ADDR_MARGIN 4'h5
`define TLTG_ADDR_PITCH 4'h6
`define TLTG_ADDR_PEAK_CUR 4'h7
`define TLTG_ADDR_RATED_CUR 4'h8
`define TLTG_ADDR_STOP_SEQ 4'h9
`define TLTG_ADDR_CONTROL 4'hA
`define TLTG_ADDR_STATUS 4'hB
`define TLTG_ADDR_ACTIVE 4'hC
`define TLTG_ADDR_MAX_LIMIT 4'hD
`define TLTG_ADDR_RANGE_LO 4'hE
`define TLTG_ADDR_RANGE_HI 4'hF
`define TLTG_LIMIT_MAX 10'h1F4
`define TLTG_MARGIN_MAX 10'h3E8
`define TLTG_RST_LIMIT 10'h1F4
`define TLTG_RST_METHOD 3'h1
`define TLTG_RST_MARGIN 10'h00A
`define TLTG_RST_PITCH 16'h0100
`define TLTG_RST_PEAK 16'h0064
`define TLTG_RST_RATED 16'h0023
`define TLTG_MODE_POS 2'h0
`define TLTG_MODE_VEL 2'h1
`define TLTG_MODE_THR 2'h2
`define TLTG_CTRL_CLR_BIT 0
`define TLTG_SQRT2_Q14 16'h5A82
`define TLTG_DIV_STEPS 6'h20
`endif

//--- design/tltg_divider.v
// Sequential unsigned divider for the largest usable thrust limit.
// Assumes start is a one-cycle pulse; result holds until next done.
`timescale 1ns/1ns
`default_nettype none
`include "tltg_consts.vh"
module tltg_divider (
  input wire sys_clk,
  input wire rst_b,
  input wire start,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  output reg [31:0] quotient_q,
  output reg done_q
);
  reg [31:0] rem_q;
  reg [31:0] num_q;
  reg [31:0] den_q;
  reg [5:0] cnt_q;
  reg busy_q;
  wire [32:0] trial;
  assign trial = {rem_q, num_q[31]} - {1'b0, den_q};

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rem_q <= 32'h0;
      num_q <= 32'h0;
      den_q <= 32'h0;
      cnt_q <= 6'h0;
      busy_q <= 1'b0;
      quotient_q <= 32'h0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        rem_q <= 32'h0;
        num_q <= dividend;
        den_q <= divisor;
        cnt_q <= `TLTG_DIV_STEPS;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        // Restoring division, one quotient bit per clock
        if (!trial[32])
        begin
          rem_q <= trial[31:0];
          num_q <= {num_q[30:0], 1'b1};
        end
        else
        begin
          rem_q <= {rem_q[30:0], num_q[31]};
          num_q <= {num_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h1;
        if (cnt_q == 6'h1)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          // Zero divisor saturates rather than reporting garbage
          quotient_q <= (den_q == 32'h0) ? 32'hFFFFFFFF :
                        (!trial[32] ? {num_q[30:0], 1'b1} : {num_q[30:0], 1'b0});
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tltg_upper_model.sv
// Upper motion controller model: mode, servo, limit switching and position commands.
// Assumes the bench calls its tasks; every output changes just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module tltg_upper_model (
  input wire logic sys_clk,
  output logic [1:0] control_mode,
  output logic servo_on,
  output logic thrust_limit_switch_cmd,
  output logic move_dir_neg,
  output logic cmd_valid,
  output logic signed [31:0] cmd_delta,
  output logic signed [31:0] motor_position
);
  initial
  begin
    control_mode = 2'h1;
    servo_on = 1'b0;
    thrust_limit_switch_cmd = 1'b0;
    move_dir_neg = 1'b0;
    cmd_valid = 1'b0;
    cmd_delta = 32'h5A5A5A5A;
    motor_position = 32'h0;
  end
  // Modes change only at rest; the controller keeps its own limits meanwhile
  task set_state(input logic [1:0] mode, input logic son, input logic sw);
    begin
      @(posedge sys_clk);
      control_mode <= mode;
      servo_on <= son;
      thrust_limit_switch_cmd <= sw;
    end
  endtask
  task command(input logic signed [31:0] delta);
    begin
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_delta <= delta;
      move_dir_neg <= delta[31];
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      // Stale delta is inverted so a late sample cannot pass by luck
      cmd_delta <= ~delta;
    end
  endtask
  task place(input logic signed [31:0] pos);
    begin
      @(posedge sys_clk);
      motor_position <= pos;
    end
  endtask
endmodule
`default_nettype wire

//--- tb/tltg_core_asserts.sv
// Port checker for the thrust limit selector and travel guard.
// Assumes it is bound into tltg_core and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module tltg_core_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] control_mode,
  input wire logic servo_on,
  input wire logic thrust_limit_switch_cmd,
  input wire logic freq_resp_active,
  input wire logic [9:0] pos_thrust_limit_q,
  input wire logic [9:0] neg_thrust_limit_q,
  input wire logic software_limit_alarm_q,
  input wire logic [2:0] alarm_stop_req_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_guard_mode:
    assert property (control_mode != 2'h0 |=> !$rose(software_limit_alarm_q))
    else $error("alarm rose outside position mode");
  a_guard_servo:
    assert property (!servo_on |=> !$rose(software_limit_alarm_q))
    else $error("alarm rose with servo off");
  a_guard_freq:
    assert property (freq_resp_active |=> !$rose(software_limit_alarm_q))
    else $error("alarm rose during frequency response");
  a_alarm_sticky:
    assert property ($rose(software_limit_alarm_q) |-> software_limit_alarm_q [*8])
    else $error("alarm dropped after trip");
  a_stop_hold:
    assert property (software_limit_alarm_q |=> $stable(alarm_stop_req_q))
    else $error("stop request changed after trip");
  a_stop_idle:
    assert property (!software_limit_alarm_q |-> alarm_stop_req_q == 3'h0)
    else $error("stop request without alarm");
  a_limit_cap:
    assert property (pos_thrust_limit_q <= 10'h1F4 && neg_thrust_limit_q <= 10'h1F4)
    else $error("thrust limit above 500");
  a_thrust_same:
    assert property (control_mode == 2'h2 |=> pos_thrust_limit_q == neg_thrust_limit_q)
    else $error("limits differ in thrust mode");
  c_trip: cover property ($rose(software_limit_alarm_q));
  c_thrust: cover property (control_mode == 2'h2 && thrust_limit_switch_cmd);
  c_switch: cover property (servo_on && thrust_limit_switch_cmd &&
    pos_thrust_limit_q != neg_thrust_limit_q);
endmodule
bind tltg_core tltg_core_asserts i_tltg_core_asserts (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .control_mode(control_mode),
  .servo_on(servo_on),
  .thrust_limit_switch_cmd(thrust_limit_switch_cmd),
  .freq_resp_active(freq_resp_active),
  .pos_thrust_limit_q(pos_thrust_limit_q),
  .neg_thrust_limit_q(neg_thrust_limit_q),
  .software_limit_alarm_q(software_limit_alarm_q),
  .alarm_stop_req_q(alarm_stop_req_q)
);
`default_nettype wire

//--- tb/tltg_core_bench.sv
// Self-checking bench for tltg_core driven by the upper controller model.
// Assumes a 50 ns clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module tltg_core_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic freq_resp_active = 1'b0;
  logic deviation_clear = 1'b0;
  logic position_init = 1'b0;
  logic [31:0] reg_rdata_q;
  logic [1:0] control_mode;
  logic servo_on, thrust_limit_switch_cmd, move_dir_neg, cmd_valid;
  logic signed [31:0] cmd_delta, motor_position;
  logic [9:0] pos_thrust_limit_q, neg_thrust_limit_q;
  logic software_limit_alarm_q;
  logic [2:0] alarm_stop_req_q;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [31:0] rval;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer seed = 32'h7C09;
  integer i;
  always #25 sys_clk = ~sys_clk;
  tltg_core i_tltg_core (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .control_mode(control_mode), .servo_on(servo_on),
    .thrust_limit_switch_cmd(thrust_limit_switch_cmd), .move_dir_neg(move_dir_neg),
    .freq_resp_active(freq_resp_active), .deviation_clear(deviation_clear),
    .position_init(position_init),
    .cmd_valid(cmd_valid), .cmd_delta(cmd_delta), .motor_position(motor_position),
    .pos_thrust_limit_q(pos_thrust_limit_q), .neg_thrust_limit_q(neg_thrust_limit_q),
    .software_limit_alarm_q(software_limit_alarm_q), .alarm_stop_req_q(alarm_stop_req_q));
  tltg_upper_model i_tltg_upper_model (.sys_clk(sys_clk), .control_mode(control_mode),
    .servo_on(servo_on), .thrust_limit_switch_cmd(thrust_limit_switch_cmd),
    .move_dir_neg(move_dir_neg), .cmd_valid(cmd_valid), .cmd_delta(cmd_delta),
    .motor_position(motor_position));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task reg_write(input logic [3:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task reg_read(input logic [3:0] a, input logic [31:0] d);
    begin
      exp_q.push_back(d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
    end
  endtask
  task lim(input logic [9:0] p, input logic [9:0] n);
    begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check("positive limit", {22'h0, pos_thrust_limit_q}, {22'h0, p});
      check("negative limit", {22'h0, neg_thrust_limit_q}, {22'h0, n});
    end
  endtask
  task guard(input logic signed [31:0] pos, input logic exp);
    begin
      i_tltg_upper_model.place(pos);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check("alarm", {31'h0, software_limit_alarm_q}, {31'h0, exp});
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(negedge sys_clk)
  begin
    if (rd_pend)
      check("read data", reg_rdata_q, exp_q.size() ? exp_q.pop_front() : 32'hX);
    rd_pend = reg_rd;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    // The max-limit divider needs 33 cycles after release
    repeat (40) @(posedge sys_clk);
    reg_read(4'h0, 32'h1F4);
    reg_read(4'h1, 32'h1F4);
    reg_read(4'h5, 32'hA);
    reg_read(4'hD, (32'h64 * 32'h64 * 32'h4000) / (32'h23 * 32'h5A82));
    rval = {$random(seed)} % 32'h1F4;
    reg_write(4'h0, rval);
    reg_read(4'h0, rval);
    reg_write(4'h1, 32'h2BC);
    reg_read(4'h1, 32'h1F4);
    reg_write(4'h5, 32'h5DC);
    reg_read(4'h5, 32'h3E8);
    for (i = 1; i <= 4; i = i + 1)
    begin
      reg_write(4'h4, i);
      reg_read(4'h4, i);
    end
    reg_write(4'h4, 32'h7);
    reg_read(4'h4, 32'h4);
    $display("test registers done");
    reg_write(4'h0, 32'h64);
    reg_write(4'h1, 32'h96);
    reg_write(4'h2, 32'h50);
    reg_write(4'h3, 32'h3C);
    i_tltg_upper_model.set_state(2'h1, 1'b1, 1'b1);
    lim(10'h50, 10'h3C);
    i_tltg_upper_model.set_state(2'h0, 1'b1, 1'b0);
    lim(10'h64, 10'h64);
    i_tltg_upper_model.set_state(2'h2, 1'b1, 1'b1);
    lim(10'h64, 10'h64);
    i_tltg_upper_model.set_state(2'h1, 1'b0, 1'b1);
    lim(10'h64, 10'h64);
    i_tltg_upper_model.set_state(2'h1, 1'b1, 1'b1);
    reg_write(4'h4, 32'h3);
    lim(10'h96, 10'h96);
    reg_write(4'h4, 32'h1);
    lim(10'h64, 10'h96);
    i_tltg_upper_model.set_state(2'h3, 1'b1, 1'b1);
    lim(10'h64, 10'h64);
    i_tltg_upper_model.set_state(2'h1, 1'b1, 1'b1);
    reg_write(4'h4, 32'h2);
    i_tltg_upper_model.command(-32'sd1);
    lim(10'h96, 10'h96);
    i_tltg_upper_model.command(32'sd1);
    lim(10'h64, 10'h64);
    reg_write(4'h8, 32'h64);
    repeat (40) @(posedge sys_clk);
    reg_read(4'hD, (32'h64 * 32'h64 * 32'h4000) / (32'h64 * 32'h5A82));
    lim(10'h46, 10'h46);
    $display("test limits done");
    reg_write(4'h5, 32'h2);
    reg_write(4'h6, 32'h10);
    reg_write(4'h9, 32'h3);
    guard(32'd5000, 1'b0);
    i_tltg_upper_model.set_state(2'h0, 1'b1, 1'b0);
    guard(32'd5032, 1'b0);
    guard(32'd4968, 1'b0);
    i_tltg_upper_model.command(32'sd100);
    guard(32'd5132, 1'b0);
    i_tltg_upper_model.command(-32'sd300);
    guard(32'd4768, 1'b0);
    freq_resp_active <= 1'b1;
    guard(32'd9000, 1'b0);
    guard(32'd4768, 1'b0);
    @(posedge sys_clk);
    freq_resp_active <= 1'b0;
    reg_read(4'hE, 32'h12A0);
    reg_read(4'hF, 32'h140C);
    @(posedge sys_clk);
    position_init <= 1'b1;
    @(posedge sys_clk);
    position_init <= 1'b0;
    reg_read(4'hE, 32'h1280);
    reg_read(4'hF, 32'h12C0);
    i_tltg_upper_model.place(32'h12B6);
    @(posedge sys_clk);
    deviation_clear <= 1'b1;
    @(posedge sys_clk);
    deviation_clear <= 1'b0;
    reg_read(4'hE, 32'h1296);
    reg_read(4'hF, 32'h12D6);
    i_tltg_upper_model.set_state(2'h1, 1'b1, 1'b0);
    guard(32'd20000, 1'b0);
    i_tltg_upper_model.set_state(2'h0, 1'b1, 1'b0);
    guard(32'd20032, 1'b0);
    guard(32'd20033, 1'b1);
    check("stop request", {29'h0, alarm_stop_req_q}, 32'h3);
    reg_read(4'hB, 32'h7);
    reg_write(4'h9, 32'h5);
    guard(32'd20000, 1'b1);
    check("stop request", {29'h0, alarm_stop_req_q}, 32'h3);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    guard(32'd20000, 1'b0);
    $display("test guard done");
    repeat (3) @(posedge sys_clk);
    check("pending reads", exp_q.size(), 32'h0);
    finish_test;
  end
endmodule
`default_nettype wire
